// ===== design/tdsa_controller.sv
// Controller end: phase generator, data and store drive for both registers.
`timescale 1ns/1ps
module tdsa_controller
    import tdsa_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic [1:0] RUN,
    input wire logic [1:0] DATA_IN,
    input wire logic [1:0] RECIRCULATE,
    input wire logic CASCADE,
    output logic [1:0] BIT_STROBE,
    output logic [1:0] DATA_OUT,
    tdsa_link_if.controller LINK
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        tdsa_phase_t [1:0] phase;
        logic [1:0] [7:0] cnt;
        logic [1:0] active;
        logic [1:0] [3:0] phi;
        logic [1:0] din;
        logic [1:0] rec;
        logic [1:0] out_s1;
        logic [1:0] out_s2;
        logic [1:0] strobe;
        logic [1:0] dout;
    } tdsa_ctl_t;

    tdsa_ctl_t st_reg;
    tdsa_ctl_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.out_s1 = ~LINK.data_out_n;
        st_next.out_s2 = st_reg.out_s1;
        st_next.strobe = 2'b00;
        for (int i = 0; i < 2; i++) begin
            if (!st_reg.active[i]) begin
                st_next.phi[i] = 4'h0;
                if (RUN[i] && st_reg.phase[i] == TDSA_PH1) begin
                    st_next.active[i] = 1'b1;
                    st_next.cnt[i] = TDSA_CNT_RST;
                    st_next.phi[i] = 4'h1;
                end
            end else if (st_reg.cnt[i] != TDSA_PHASE_LAST) begin
                // Each phase lasts a fixed count, bounding rate at 5 MHz.
                st_next.cnt[i] = st_reg.cnt[i] + 8'h01;
            end else begin
                st_next.cnt[i] = TDSA_CNT_RST;
                // Phases advance strictly one, two, three, four.
                case (st_reg.phase[i])
                    TDSA_PH1: begin
                        st_next.phase[i] = TDSA_PH2;
                        st_next.phi[i] = 4'h2;
                    end
                    TDSA_PH2: begin
                        st_next.phase[i] = TDSA_PH3;
                        st_next.phi[i] = 4'h4;
                    end
                    TDSA_PH3: begin
                        st_next.phase[i] = TDSA_PH4;
                        st_next.phi[i] = 4'h8;
                    end
                    TDSA_PH4: begin
                        st_next.phase[i] = TDSA_PH1;
                        st_next.phi[i] = RUN[i] ? 4'h1 : 4'h0;
                        st_next.active[i] = RUN[i];
                        st_next.strobe[i] = 1'b1;
                        st_next.dout[i] = st_reg.out_s2[i];
                    end
                    default: begin
                        st_next.phase[i] = TDSA_PH1;
                        st_next.active[i] = 1'b0;
                    end
                endcase
            end
            // Load data and store during phase one; hold them steady over phases two through four.
            if (st_next.phi[i][0]) begin
                st_next.din[i] = DATA_IN[i];
                st_next.rec[i] = RECIRCULATE[i];
            end
        end
        // Cascade: second register is fed by the first one's output.
        if (CASCADE && st_next.phi[1][0]) begin
            st_next.din[1] = st_reg.out_s2[0];
            st_next.rec[1] = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Negative logic drive on the link.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            LINK.phi1_n[i] = ~st_reg.phi[i][0];
            LINK.phi2_n[i] = ~st_reg.phi[i][1];
            LINK.phi3_n[i] = ~st_reg.phi[i][2];
            LINK.phi4_n[i] = ~st_reg.phi[i][3];
        end
    end
    assign LINK.data_in_n = ~st_reg.din;
    assign LINK.recirculate_select_first_n = ~st_reg.rec[0];
    assign LINK.recirculate_select_second_n = ~st_reg.rec[1];
    assign BIT_STROBE = st_reg.strobe;
    assign DATA_OUT = st_reg.dout;
endmodule

// ===== design/tdsa_device.sv
// Device end: two 512-bit four-phase recirculating shift registers.
`timescale 1ns/1ps
module tdsa_device
    import tdsa_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_B,
    tdsa_link_if.device LINK
);
    // ------------------------------------------------------------
    // Per-register state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] phi_s1;
        logic [3:0] phi_s2;
        logic [3:0] phi_d;
        logic [1:0] in_s1;
        logic [1:0] in_s2;
        logic cap_bit;
        logic cap_done;
        logic rec_flag;
        logic seen3;
        logic [8:0] ptr;
        logic out_bit;
        logic out_n;
    } tdsa_dev_t;

    logic [1:0] rec_n;
    logic [1:0] out_n;

    assign rec_n = {LINK.recirculate_select_second_n,
                    LINK.recirculate_select_first_n};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_reg
            tdsa_dev_t st_reg;
            tdsa_dev_t st_next;
            logic mem [0:TDSA_DEPTH-1];
            logic [3:0] ph;
            logic [3:0] fall;
            logic wr_en;
            logic wr_bit;

            // Active-high phases after synchronising the negative logic.
            assign ph = st_reg.phi_s2;
            assign fall = st_reg.phi_d & ~ph;

            always_comb begin
                st_next = st_reg;
                wr_en = 1'b0;
                wr_bit = 1'b0;
                st_next.phi_s1 = ~{LINK.phi4_n[g], LINK.phi3_n[g],
                                   LINK.phi2_n[g], LINK.phi1_n[g]};
                st_next.phi_s2 = st_reg.phi_s1;
                st_next.phi_d = ph;
                st_next.in_s1 = {~rec_n[g], ~LINK.data_in_n[g]};
                st_next.in_s2 = st_reg.in_s1;
                // Sample input once at the start of phase two, after phase one ends.
                if (fall[0]) begin
                    st_next.cap_done = 1'b0;
                end
                if (ph[1] && !ph[0] && !st_reg.cap_done) begin
                    st_next.cap_bit = st_reg.in_s2[0];
                    st_next.cap_done = 1'b1;
                end
                // Store level at the trailing edge of phase three.
                if (fall[2]) begin
                    st_next.rec_flag = st_reg.in_s2[1];
                    st_next.seen3 = 1'b1;
                end
                // Shift only when a full sequence reaches phase four end.
                if (fall[3] && st_reg.seen3 && st_reg.cap_done) begin
                    wr_en = 1'b1;
                    wr_bit = st_reg.rec_flag ? mem[st_reg.ptr]
                                             : st_reg.cap_bit;
                    st_next.out_bit = mem[st_reg.ptr];
                    st_next.ptr = (st_reg.ptr == TDSA_PTR_LAST) ?
                                  TDSA_PTR_RST : st_reg.ptr + 9'h001;
                    st_next.seen3 = 1'b0;
                    st_next.cap_done = 1'b0;
                end
                // Output drives low for logic one, held until next shift.
                st_next.out_n = ~st_next.out_bit;
            end

            always_ff @(posedge CLK_SYS or negedge RST_B) begin
                if (!RST_B) begin
                    st_reg <= '0;
                    // Idle output pin rests high, meaning logic zero.
                    st_reg.out_n <= 1'b1;
                end else begin
                    st_reg <= st_next;
                end
            end

            // Dynamic store has no reset; contents are whatever was shifted.
            always_ff @(posedge CLK_SYS) begin
                if (wr_en) begin
                    mem[st_reg.ptr] <= wr_bit;
                end
            end

            // Registered output pin usable as the other input.
            assign out_n[g] = st_reg.out_n;
        end
    endgenerate

    assign LINK.data_out_n = out_n;
endmodule

// ===== design/tdsa_link_if.sv
// Pin-level link between the twin register device and its controller.
`timescale 1ns/1ps
interface tdsa_link_if;
    // Negative logic on every line: low level means logic one.
    logic [1:0] phi1_n;
    logic [1:0] phi2_n;
    logic [1:0] phi3_n;
    logic [1:0] phi4_n;
    logic [1:0] data_in_n;
    logic [1:0] data_out_n;
    logic recirculate_select_first_n;
    logic recirculate_select_second_n;
    modport device (
        input phi1_n, phi2_n, phi3_n, phi4_n, data_in_n,
        input recirculate_select_first_n, recirculate_select_second_n,
        output data_out_n
    );
    modport controller (
        output phi1_n, phi2_n, phi3_n, phi4_n, data_in_n,
        output recirculate_select_first_n, recirculate_select_second_n,
        input data_out_n
    );
endinterface

// ===== design/tdsa_pkg.sv
// Package with shared constants and types for the twin shift accumulator.
package tdsa_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int TDSA_DEPTH = 512;
    localparam int TDSA_PTR_W = 9;
    localparam logic [8:0] TDSA_PTR_LAST = 9'h1FF;
    localparam logic [8:0] TDSA_PTR_RST = 9'h000;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int TDSA_CLK_MHZ = 250;
    localparam int TDSA_PRR_MAX_KHZ = 5000;
    localparam int TDSA_PRR_MIN_KHZ = 10;
    // Cycles per phase; four phases make one bit period of at most 5 MHz.
    localparam int TDSA_PHASE_CYC =
        (TDSA_CLK_MHZ * 1000 + 4 * TDSA_PRR_MAX_KHZ - 1)
        / (4 * TDSA_PRR_MAX_KHZ);
    localparam logic [7:0] TDSA_PHASE_LAST = 8'(TDSA_PHASE_CYC - 1);
    localparam logic [7:0] TDSA_CNT_RST = 8'h00;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TDSA_PH1,
        TDSA_PH2,
        TDSA_PH3,
        TDSA_PH4
    } tdsa_phase_t;
endpackage

// ===== tb/tdsa_bench.sv
// Self-checking bench for the twin register device and its controller.
`timescale 1ns/1ps
module tdsa_bench
    import tdsa_pkg::*;
;
    localparam int NBITS = 1100;
    localparam int LIMIT = 75000;
    logic CLK_SYS = 1'b0;
    logic RST_B = 1'b0;
    logic [1:0] RUN = 2'b00;
    logic [1:0] DATA_IN = 2'b00;
    logic [1:0] RECIRCULATE = 2'b00;
    logic CASCADE = 1'b0;
    logic [1:0] BIT_STROBE;
    logic [1:0] DATA_OUT;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    tdsa_link_if link();
    tdsa_device tdsa_device_inst (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
        .LINK(link));
    tdsa_controller tdsa_controller_inst (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
        .RUN(RUN), .DATA_IN(DATA_IN), .RECIRCULATE(RECIRCULATE),
        .CASCADE(CASCADE), .BIT_STROBE(BIT_STROBE), .DATA_OUT(DATA_OUT),
        .LINK(link));
    tdsa_checker tdsa_checker_inst (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
        .phi1_n(link.phi1_n), .phi2_n(link.phi2_n), .phi3_n(link.phi3_n),
        .phi4_n(link.phi4_n), .data_in_n(link.data_in_n),
        .data_out_n(link.data_out_n),
        .recirculate_select_first_n(link.recirculate_select_first_n),
        .recirculate_select_second_n(link.recirculate_select_second_n));
    always #2 CLK_SYS = ~CLK_SYS;
    task automatic chk(input string what, input logic [1:0] seen,
                       input logic [1:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("Counts: %0d checks, %0d mismatches", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge CLK_SYS) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            bad_count++;
            conclude();
        end
    end
    // Reference store per register, compared at each bit strobe after the first 513 shifts.
    // Each strobe ends one bit; its shift result shows at the next strobe.
    task automatic lane(input int i);
        logic ref_mem [0:TDSA_DEPTH-1];
        int ptr;
        int shifts;
        logic cur_d;
        logic cur_r;
        logic rd;
        logic exp_out;
        logic have_exp;
        ptr = 0;
        shifts = 0;
        have_exp = 1'b0;
        exp_out = 1'b0;
        cur_d = DATA_IN[i];
        cur_r = 1'b0;
        for (int k = 0; k < NBITS; k++) begin
            do begin
                @(posedge CLK_SYS);
                #1;
            end while (BIT_STROBE[i] !== 1'b1);
            if (have_exp) begin
                chk("serial out", {1'b0, DATA_OUT[i]}, {1'b0, exp_out});
            end
            rd = ref_mem[ptr];
            ref_mem[ptr] = cur_r ? rd : cur_d;
            have_exp = (shifts >= TDSA_DEPTH);
            exp_out = rd;
            ptr = (ptr + 1) % TDSA_DEPTH;
            shifts++;
            cur_d = DATA_IN[i];
            cur_r = RECIRCULATE[i];
            repeat (20) @(posedge CLK_SYS);
            #1;
            DATA_IN[i] = 1'($urandom);
            RECIRCULATE[i] = (shifts >= TDSA_DEPTH) ? 1'($urandom) : 1'b0;
            if (i == 1 && k == 700) begin
                RUN[1] = 1'b0;
            end
            if (i == 1 && k == 701) begin
                repeat (300) @(posedge CLK_SYS);
                #1;
                cur_d = DATA_IN[i];
                cur_r = RECIRCULATE[i];
                RUN[1] = 1'b1;
            end
        end
    endtask
    initial begin
        void'($urandom(82298));
        repeat (5) @(posedge CLK_SYS);
        #1;
        chk("idle phases", link.phi1_n & link.phi2_n & link.phi3_n
            & link.phi4_n, 2'b11);
        chk("idle input", link.data_in_n, 2'b11);
        chk("idle output", DATA_OUT, 2'b00);
        chk("idle serial pin", link.data_out_n, 2'b11);
        repeat (5) @(posedge CLK_SYS);
        #1;
        RST_B = 1'b1;
        $display("Test reset idle done");
        DATA_IN = 2'($urandom);
        RUN = 2'b11;
        // Both registers run side by side, as when interleaved.
        fork
            lane(0);
            lane(1);
        join
        $display("Test stream and recirculate done");
        conclude();
    end
endmodule

// ===== tb/tdsa_checker.sv
// Checker for the link between the twin register device and its controller.
`timescale 1ns/1ps
module tdsa_checker
    import tdsa_pkg::*;
(
    input logic CLK_SYS,
    input logic RST_B,
    input logic [1:0] phi1_n,
    input logic [1:0] phi2_n,
    input logic [1:0] phi3_n,
    input logic [1:0] phi4_n,
    input logic [1:0] data_in_n,
    input logic [1:0] data_out_n,
    input logic recirculate_select_first_n,
    input logic recirculate_select_second_n
);
    localparam int PH_END = TDSA_PHASE_CYC - 7;
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_B);
    a_pair_overlap: assert property (
        ((~phi1_n | ~phi2_n) & (~phi3_n | ~phi4_n)) == 2'b00)
        else $error("Forbidden phase overlap.");
    a_phase_width: assert property (
        $fell(phi1_n[0]) |-> !phi1_n[0] [*8] ##PH_END phi1_n[0])
        else $error("First phase width wrong.");
    a_order_second: assert property (
        $rose(phi1_n[0]) |-> ##[0:1] !phi2_n[0])
        else $error("Second phase did not follow the first.");
    a_order_third: assert property (
        $rose(phi2_n[1]) |-> ##[0:1] !phi3_n[1])
        else $error("Third phase did not follow the second.");
    a_order_fourth: assert property (
        $rose(phi3_n[0]) |-> ##[0:1] !phi4_n[0])
        else $error("Fourth phase did not follow the third.");
    a_data_hold: assert property (
        (!phi1_n[1] || !phi2_n[1]) && $past(!phi1_n[1] || !phi2_n[1])
        |-> $stable(data_in_n[1]))
        else $error("Serial input moved during capture.");
    a_store_first: assert property (
        $rose(phi3_n[0]) |-> $stable(recirculate_select_first_n))
        else $error("First store moved at third phase end.");
    a_store_second: assert property (
        $rose(phi3_n[1]) |-> $stable(recirculate_select_second_n))
        else $error("Second store moved at third phase end.");
    a_out_hold: assert property (
        (!phi2_n[0] || !phi3_n[0]) |-> $stable(data_out_n[0]))
        else $error("Serial output moved while valid.");
    cover property ($rose(phi4_n[0]));
    cover property (!recirculate_select_first_n && $rose(phi3_n[0]));
    cover property (!recirculate_select_second_n && $rose(phi3_n[1]));
endmodule
